// File: pll_scan_pkg.sv
// Shared constants for the PLL scan reconfiguration block.
package pll_scan_pkg;
  // Scan chain geometry.
  localparam int unsigned CHAIN_LEN  = 144;
  localparam int unsigned SEG_W      = 18;
  localparam int unsigned NUM_DIV    = 7;
  localparam int unsigned NUM_OUT    = 5;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned BW_W       = 9;
  localparam int unsigned PUMP_BASE  = NUM_DIV * SEG_W;
  localparam int unsigned FILT_BASE  = PUMP_BASE + BW_W;
  // Field positions inside one divider segment.
  localparam int unsigned LOW_POS    = 0;
  localparam int unsigned HIGH_POS   = 8;
  localparam int unsigned BYP_POS    = 16;
  localparam int unsigned ODD_POS    = 17;
  // Divider index inside the chain: outputs first, then feedback, prescale.
  localparam int unsigned FB_IDX     = 5;
  localparam int unsigned PRE_IDX    = 6;
  // Shift counter width and full-load value.
  localparam int unsigned SCNT_W     = 8;
  localparam logic [7:0]  SCNT_FULL  = 8'h90;
  // Rates: core clock and the fastest allowed scan clock.
  localparam int unsigned CORE_MHZ   = 200;
  localparam int unsigned SCAN_MHZ   = 100;
  localparam int unsigned SCAN_MIN_CYC = (CORE_MHZ + SCAN_MHZ - 1) / SCAN_MHZ;
  // Register byte offsets.
  localparam logic [7:0]  STATUS_OFF = 8'h00;
  localparam logic [7:0]  MASK_OFF   = 8'h04;
  localparam logic [7:0]  STATE_OFF  = 8'h08;
  localparam logic [7:0]  BW_OFF     = 8'h0C;
  // Status and mask bit positions.
  localparam int unsigned EV_DONE    = 0;
  localparam int unsigned EV_ERR     = 1;
  localparam int unsigned EV_W       = 2;
  // Reset values.
  localparam logic [1:0]  MASK_RST   = 2'h0;
  localparam logic [8:0]  BW_RST     = 9'h000;
  localparam logic [7:0]  CNT_RST    = 8'h01;
  localparam logic        BYP_RST    = 1'b1;
  localparam logic        ODD_RST    = 1'b0;
  // Load sequencer states, Gray coded.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } load_state_e;
endpackage

// File: scan_chain.sv
// Serial scan shift register with serial readback.
`timescale 1ns/1ps
module scan_chain #(
  parameter int unsigned LEN = 144
) (
  input  wire logic           core_clk_i,
  input  wire logic           rstn_i,
  input  wire logic           shift_i,
  input  wire logic           data_i,
  output logic [LEN-1:0]      chain_o,
  output logic                data_o
);
  initial begin
    if (LEN < 2) $error("scan_chain: LEN too small");
  end

  // New bits enter at the top, so after a full load the first bit sits at
  // index zero; the chain holds its contents while shift is low.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chain_o <= '0;
    end else if (shift_i) begin
      chain_o <= {data_i, chain_o[LEN-1:1]};
    end
  end

  // The bottom bit is the one that leaves next; registered for a clean pin.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= 1'b0;
    end else if (shift_i) begin
      data_o <= chain_o[1];
    end else begin
      data_o <= chain_o[0];
    end
  end
endmodule

// File: scan_divider.sv
// One reprogrammable divider with high/low counts, bypass and odd mode.
`timescale 1ns/1ps
module scan_divider #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] high_i,
  input  wire logic [W-1:0] low_i,
  input  wire logic         bypass_i,
  input  wire logic         odd_i,
  output logic              div_o,
  output logic              adopted_o
);
  import pll_scan_pkg::*;

  localparam int unsigned HW = W + 2; // Counts run in half VCO periods.

  logic [W-1:0]  pend_high;    // Settings waiting for the period end.
  logic [W-1:0]  pend_low;
  logic          pend_byp;
  logic          pend_odd;
  logic          pending;      // A new setting is waiting.
  logic [W-1:0]  cur_high;     // Settings in effect.
  logic [W-1:0]  cur_low;
  logic          cur_byp;
  logic          cur_odd;
  logic [HW-1:0] cnt;          // Half-period position inside the cycle.
  logic [HW-1:0] period_h;     // Cycle length in half periods.
  logic [HW-1:0] high_h;       // High time in half periods.
  logic          boundary;     // Last half period of the output cycle.

  initial begin
    if (W < 2) $error("scan_divider: W too small");
  end

  // Bypass and all-zero counts both give one VCO period, high for one half.
  always_comb begin
    if (cur_byp || (cur_high == '0 && cur_low == '0)) begin
      period_h = HW'(2);
      high_h   = HW'(1);
    end else begin
      period_h = HW'({cur_high, 1'b0}) + HW'({cur_low, 1'b0});
      // Odd mode moves the fall to a falling VCO edge: half a period less.
      high_h   = HW'({cur_high, 1'b0}) - HW'(cur_odd);
    end
  end

  assign boundary = (cnt >= period_h - HW'(1));

  // Capture a new setting; it waits until the current cycle finishes.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_high <= W'(CNT_RST);
      pend_low  <= W'(CNT_RST);
      pend_byp  <= BYP_RST;
      pend_odd  <= ODD_RST;
      pending   <= 1'b0;
    end else if (load_i) begin
      pend_high <= high_i;
      pend_low  <= low_i;
      pend_byp  <= bypass_i;
      pend_odd  <= odd_i;
      pending   <= 1'b1;
    end else if (boundary) begin
      pending   <= 1'b0;
    end
  end

  // Adopt at this divider's own cycle end, so dividers switch independently.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_high  <= W'(CNT_RST);
      cur_low   <= W'(CNT_RST);
      cur_byp   <= BYP_RST;
      cur_odd   <= ODD_RST;
      adopted_o <= 1'b0;
    end else begin
      adopted_o <= pending && boundary && !load_i;
      if (pending && boundary && !load_i) begin
        cur_high <= pend_high;
        cur_low  <= pend_low;
        cur_byp  <= pend_byp;
        cur_odd  <= pend_odd;
      end
    end
  end

  // Half-period counter and registered output.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt   <= '0;
      div_o <= 1'b0;
    end else begin
      cnt   <= boundary ? '0 : cnt + HW'(1);
      div_o <= boundary ? 1'b1 : (cnt + HW'(1) < high_h);
    end
  end
endmodule

// File: pll_scan_reconfig.sv
// Top of the PLL scan reconfiguration block: sequencing, load and registers.
`timescale 1ns/1ps

// Functional notes
// - Chain is 144 bits; full load required.
// - Capture from second rising edge, bit each.
// - Chain holds while enable low.
// - One-cycle apply strobe loads chain into settings.
// - Done high while busy, fall means applied.
// - Each divider switches on its own clock.
// - Sequence may repeat without limit.
// - Chain contents appear on serial output.
// - Scan never changes phase selections.
// - Eight-bit high and low counts per divider.
// - Bypass one passes input undivided.
// - Odd clear: fall on rising VCO edge.
// - Odd set: fall on falling edge.
// - Seven 18-bit dividers, two 9-bit segments.
// - First bit fifth output low LSB; filter MSB last.
module pll_scan_reconfig (
  input  wire logic                             core_clk_i,
  input  wire logic                             rstn_i,
  input  wire logic                             scan_clk_i,
  input  wire logic                             scan_en_i,
  input  wire logic                             scan_data_i,
  input  wire logic                             apply_i,
  output logic                                  done_o,
  output logic                                  scan_data_o,
  input  wire logic [7:0]                       reg_addr_i,
  input  wire logic [31:0]                      reg_wdata_i,
  input  wire logic                             reg_we_i,
  input  wire logic                             reg_re_i,
  output logic [31:0]                           reg_rdata_o,
  output logic                                  irq_o,
  output logic [pll_scan_pkg::NUM_OUT-1:0]      output_dividers_o,
  output logic                                  fb_div_o,
  output logic                                  pre_div_o,
  output logic [pll_scan_pkg::BW_W-1:0]         pump_current_setting_o,
  output logic [pll_scan_pkg::BW_W-1:0]         filter_setting_o
);
  import pll_scan_pkg::*;

  logic                  scan_clk_q;    // Previous scan clock sample.
  logic                  scan_rise;     // Rising scan edge seen this cycle.
  logic                  en_q;          // Enable at the previous scan edge.
  logic                  apply_q;       // Apply at the previous scan edge.
  logic                  shift;         // Shift the chain this cycle.
  logic [SCNT_W-1:0]     shift_cnt;     // Bits shifted in this load.
  logic [CHAIN_LEN-1:0]  chain;         // Scan chain contents.
  logic                  apply_edge;    // Fresh apply seen on a scan edge.
  logic                  accept;        // Apply taken for a full load.
  logic                  reject;        // Apply refused.
  load_state_e           state;         // Load sequencer state.
  logic                  load;          // Hand new settings to dividers.
  logic [NUM_DIV-1:0]    adopted;       // Adoption pulses from dividers.
  logic [NUM_DIV-1:0]    adopted_set;   // Dividers that took the new value.
  logic [NUM_DIV-1:0]    div_clk;       // All divider outputs.
  logic                  all_adopted;   // Every divider has switched.
  logic [EV_W-1:0]       status;        // Sticky event bits.
  logic [EV_W-1:0]       mask;          // Interrupt enables.
  logic [EV_W-1:0]       events;        // Event pulses this cycle.
  logic [EV_W-1:0]       w1c;           // Bits software clears this cycle.
  logic [31:0]           next_rdata;    // Read data selected by address.

  // The scan clock is sampled on the core clock; at up to half the core
  // rate each scan level lasts at least one core cycle, so no edge is lost.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_clk_q <= 1'b0;
    end else begin
      // Follow the pin every cycle.
      scan_clk_q <= scan_clk_i;
    end
  end

  assign scan_rise = scan_clk_i && !scan_clk_q;

  // Enable and apply are registered on scan edges, as the PLL would.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q    <= 1'b0;
      apply_q <= 1'b0;
    end else if (scan_rise) begin
      // Only scan edges move these.
      en_q    <= scan_en_i;
      apply_q <= apply_i;
    end
  end

  // The first edge with enable high only arms; data enter from the second.
  assign shift = scan_rise && scan_en_i && en_q;

  // Count bits of the current load; a new enable window starts afresh.
  // The count saturates so an overlong load still reads as full.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_cnt <= '0;
    end else if (scan_rise && scan_en_i && !en_q) begin
      // A fresh window restarts.
      shift_cnt <= '0;
    end else if (shift && shift_cnt != SCNT_FULL) begin
      // Count up, stop at full.
      shift_cnt <= shift_cnt + SCNT_W'(1);
    end
  end

  // The chain shifts only inside the enable window.
  scan_chain #(
    .LEN (CHAIN_LEN)
  ) u_chain (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .shift_i    (shift),
    .data_i     (scan_data_i),
    .chain_o    (chain),
    .data_o     (scan_data_o)
  );

  // An apply counts once per strobe, taken on its first scan edge.
  assign apply_edge = scan_rise && apply_i && !apply_q;
  // A short load or an apply while busy would load a half-built chain.
  assign accept = apply_edge && (shift_cnt == SCNT_FULL) &&
                  !scan_en_i && (state == ST_IDLE);
  // Anything else is refused.
  assign reject = apply_edge && !accept;
  assign load   = accept;

  // Sequencer: busy from the accepted apply until every divider switched.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            // Busy until all switch.
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Leave once all switched.
          if (all_adopted) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Track which dividers have taken their new setting.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adopted_set <= '0;
    end else if (load) begin
      adopted_set <= '0;
    end else if (state == ST_WAIT) begin
      // Gather pulses while busy.
      adopted_set <= adopted_set | adopted;
    end
  end

  // This cycle's pulses count too.
  assign all_adopted = &(adopted_set | adopted);

  // Done is high exactly while busy; its fall marks new settings in force.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
    end else begin
      // High from accept on.
      done_o <= accept || (state == ST_WAIT && !all_adopted);
    end
  end

  // One divider per chain segment; segment i starts at bit i*18. Only the
  // counts and mode bits are loaded, phase tap choices live elsewhere.
  for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
    // Base bit of this segment.
    localparam int unsigned B = i * SEG_W;
    scan_divider #(
      .W (CNT_W)
    ) u_div (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .load_i     (load),
      .high_i     (chain[B+HIGH_POS +: CNT_W]),
      .low_i      (chain[B+LOW_POS +: CNT_W]),
      .bypass_i   (chain[B+BYP_POS]),
      .odd_i      (chain[B+ODD_POS]),
      .div_o      (div_clk[i]),
      .adopted_o  (adopted[i])
    );
  end

  // Chain order runs from the last output down, so reverse it here.
  for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
    // Output k is segment four minus k.
    assign output_dividers_o[k] = div_clk[NUM_OUT-1-k];
  end

  // Feedback and prescale follow outputs.
  assign fb_div_o  = div_clk[FB_IDX];
  assign pre_div_o = div_clk[PRE_IDX];

  // Bandwidth settings change only on an accepted apply. The PLL itself
  // still needs a clear from the controller afterwards.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pump_current_setting_o <= BW_RST;
      filter_setting_o       <= BW_RST;
    end else if (load) begin
      // Straight from the chain.
      pump_current_setting_o <= chain[PUMP_BASE +: BW_W];
      filter_setting_o       <= chain[FILT_BASE +: BW_W];
    end
  end

  // Event pulses: completion and refused apply.
  always_comb begin
    events         = '0;
    // Done is the last adoption.
    events[EV_DONE] = (state == ST_WAIT) && all_adopted;
    events[EV_ERR]  = reject;
  end

  // Write-one-to-clear mask for the status register.
  always_comb begin
    w1c = '0;
    if (reg_we_i && reg_addr_i == STATUS_OFF) begin
      // Write ones to clear.
      w1c = reg_wdata_i[EV_W-1:0];
    end
  end

  // Sticky status; an event in the clearing cycle survives the clear.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= '0;
    end else begin
      // Set wins over clear.
      status <= (status & ~w1c) | events;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask <= MASK_RST;
    end else if (reg_we_i && reg_addr_i == MASK_OFF) begin
      // Event bits only.
      mask <= reg_wdata_i[EV_W-1:0];
    end
  end

  // Level output while unmasked bits are set.
  assign irq_o = |(status & mask);

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    next_rdata = '0;
    case (reg_addr_i)
      STATUS_OFF: begin
        next_rdata[EV_W-1:0] = status;
      end
      MASK_OFF: begin
        next_rdata[EV_W-1:0] = mask;
      end
      STATE_OFF: begin
        // Busy, count and adoption mask.
        next_rdata[0]     = (state == ST_WAIT);
        next_rdata[15:8]  = shift_cnt;
        next_rdata[22:16] = adopted_set;
      end
      BW_OFF: begin
        // Both bandwidth settings.
        next_rdata[8:0]   = pump_current_setting_o;
        next_rdata[24:16] = filter_setting_o;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      // Latch the addressed word.
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule

// File: pll_scan_sva.sv
// Checker for the scan, apply and register read timing of the block.
`timescale 1ns/1ps
module pll_scan_sva (
  input wire logic                         core_clk_i,
  input wire logic                         rstn_i,
  input wire logic                         scan_clk_i,
  input wire logic                         scan_en_i,
  input wire logic                         apply_i,
  input wire logic                         done_o,
  input wire logic                         scan_data_o,
  input wire logic [7:0]                   reg_addr_i,
  input wire logic                         reg_re_i,
  input wire logic [31:0]                  reg_rdata_o,
  input wire logic [pll_scan_pkg::BW_W-1:0] pump_current_setting_o,
  input wire logic [pll_scan_pkg::BW_W-1:0] filter_setting_o
);
  import pll_scan_pkg::*;
  logic sclk_q;  // Scan clock level at the previous core edge.
  logic accept;  // A scan edge that may take an apply.
  logic shift;   // A scan edge with the enable high.
  // Keep the old scan level so scan edges are seen on the core clock.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= scan_clk_i;
    end
  end
  assign accept = scan_clk_i & ~sclk_q & apply_i & ~scan_en_i;
  assign shift  = scan_clk_i & ~sclk_q & scan_en_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // The output bit may lag its shift edge by up to two cycles.
  sequence s_shift_seen;
    $past(shift) || $past(shift, 2);
  endsequence
  sequence s_done_end;
    ##32 ##[1:1000] !done_o;
  endsequence
  property p_sdo_moves;
    $changed(scan_data_o) |-> s_shift_seen;
  endproperty
  property p_done_bound;
    $rose(done_o) |-> s_done_end;
  endproperty
  property p_done_cause;
    $rose(done_o) |-> $past(accept);
  endproperty
  property p_done_en;
    $rose(done_o) |-> !$past(scan_en_i);
  endproperty
  property p_set_hold;
    $changed(pump_current_setting_o) || $changed(filter_setting_o)
      |-> $rose(done_o);
  endproperty
  property p_bw_read;
    reg_re_i && reg_addr_i == BW_OFF |=> reg_rdata_o == {7'h00,
      $past(filter_setting_o), 7'h00, $past(pump_current_setting_o)};
  endproperty
  property p_unmapped;
    reg_re_i && reg_addr_i > BW_OFF |=> reg_rdata_o == 32'h0;
  endproperty
  property p_rd_idle;
    !reg_re_i |=> reg_rdata_o == 32'h0;
  endproperty
  a_sdo_moves: assert property (p_sdo_moves)
    else $error("serial output moved without a shift");
  a_done_bound: assert property (p_done_bound)
    else $error("done stayed high too long");
  a_done_cause: assert property (p_done_cause)
    else $error("done rose without an accepted apply");
  a_done_en: assert property (p_done_en)
    else $error("done rose while enable high");
  a_set_hold: assert property (p_set_hold)
    else $error("settings changed outside an apply");
  a_bw_read: assert property (p_bw_read)
    else $error("bandwidth read mismatch");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without a read");
endmodule

bind pll_scan_reconfig pll_scan_sva u_sva (
  .core_clk_i            (core_clk_i),
  .rstn_i                (rstn_i),
  .scan_clk_i            (scan_clk_i),
  .scan_en_i             (scan_en_i),
  .apply_i               (apply_i),
  .done_o                (done_o),
  .scan_data_o           (scan_data_o),
  .reg_addr_i            (reg_addr_i),
  .reg_re_i              (reg_re_i),
  .reg_rdata_o           (reg_rdata_o),
  .pump_current_setting_o(pump_current_setting_o),
  .filter_setting_o      (filter_setting_o)
);

// File: scan_ctrl_model.sv
// Behavioural controller that loads the scan chain and applies it.
`timescale 1ns/1ps
module scan_ctrl_model (
  input  wire logic clk_i,
  input  wire logic done_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      en_o,
  output logic      sdi_o,
  output logic      apply_o
);
  logic [143:0] rb;        // Bits seen on the serial output per shift.
  int           done_cnt;  // Count of done rises.
  logic         done_q;    // Done level at the previous edge.
  initial begin
    sclk_o = 1'b0;
    en_o = 1'b0;
    sdi_o = 1'b0;
    apply_o = 1'b0;
    rb = '0;
    done_cnt = 0;
    done_q = 1'b0;
  end
  // Count done rises; a short busy time could hide inside a pulse.
  always @(posedge clk_i) begin
    done_q <= done_i;
    if (done_i === 1'b1 && done_q !== 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
  end
  // One scan period of four core cycles or more, so 50 MHz at most.
  task pulse(input int gap);
    @(posedge clk_i) sclk_o <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i) sclk_o <= 1'b0;
    repeat (1 + gap) @(posedge clk_i);
  endtask
  // Arm, shift n bits first bit first, drop enable unless hold is set, then apply once.
  task load(input logic [143:0] b, input int n, input logic hold,
            input int gap);
    int i;
    @(posedge clk_i);
    en_o <= 1'b1;
    pulse(gap);
    for (i = 0; i < n; i++) begin
      sdi_o <= b[i];
      rb[i] <= sdo_i;
      pulse(gap);
    end
    en_o <= hold;
    sdi_o <= ~sdi_o;
    pulse(gap);
    apply_o <= 1'b1;
    pulse(gap);
    apply_o <= 1'b0;
    sdi_o <= ~sdi_o;
    en_o <= 1'b0;
  endtask
endmodule

// File: tb.sv
// Testbench: scan loads, refused applies, dividers and registers.
`timescale 1ns/1ps
module tb;
  import pll_scan_pkg::*;
  logic                clk;
  logic                rstn;
  logic                sclk;
  logic                sen;
  logic                sdi;
  logic                apply;
  logic                done;
  logic                sdo;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic                we;
  logic                re;
  logic                irq;
  logic [NUM_OUT-1:0]  odiv;
  logic                fb;
  logic                pre;
  logic [BW_W-1:0]     pump;
  logic [BW_W-1:0]     filt;
  logic [143:0]        b1;
  logic [143:0]        b2;
  int                  error_cnt;
  int                  comparisons;
  int                  cyc;
  pll_scan_reconfig dut (
    .core_clk_i(clk), .rstn_i(rstn), .scan_clk_i(sclk), .scan_en_i(sen),
    .scan_data_i(sdi), .apply_i(apply), .done_o(done), .scan_data_o(sdo),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .irq_o(irq), .output_dividers_o(odiv),
    .fb_div_o(fb), .pre_div_o(pre), .pump_current_setting_o(pump),
    .filter_setting_o(filt)
  );
  scan_ctrl_model m (
    .clk_i(clk), .done_i(done), .sdo_i(sdo), .sclk_o(sclk), .en_o(sen),
    .sdi_o(sdi), .apply_o(apply)
  );
  always #2.5 clk = ~clk;
  // Cut a hang short; the whole run needs about 2800 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end
  task finish_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_v(input string n, input logic [143:0] e, input logic [143:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
  endtask
  // Read data stand only in the cycle after the strobe.
  task reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  function automatic logic [17:0] seg(input logic [7:0] h,
    input logic [7:0] l, input logic byp, input logic odd);
    return {odd, byp, h, l};
  endfunction
  // Unused dividers stay bypassed.
  function automatic logic [143:0] frame(input logic [17:0] c0,
    input logic [17:0] c1, input logic [17:0] c2, input logic [8:0] p,
    input logic [8:0] f);
    logic [17:0] by;
    by = seg(8'h01, 8'h01, 1'b1, 1'b0);
    return {f, p, by, by, c0, c1, c2, by, by};
  endfunction
  task run(input int k, input logic v, output int n);
    n = 0;
    while (odiv[k] === v && n < 600) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Align to a rise, then time one high and one low phase.
  task meas(input int k, input int hi, input int per);
    int h;
    int l;
    run(k, 1'b1, h);
    run(k, 1'b0, l);
    run(k, 1'b1, h);
    run(k, 1'b0, l);
    chk("div_high", 32'(hi), 32'(h));
    chk("div_period", 32'(per), 32'(h + l));
  endtask
  task wait_idle();
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (done !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("done_idle", 32'h0, 32'(done));
  endtask
  task t_regs();
    logic [31:0] d;
    reg_rd(MASK_OFF, d);
    chk("mask_rst", 32'(MASK_RST), d);
    reg_rd(BW_OFF, d);
    chk("bw_rst", 32'h0, d);
    reg_rd(8'h10, d);
    chk("unmapped", 32'h0, d);
    reg_wr(MASK_OFF, 32'h1);
  endtask
  task t_load1();
    logic [31:0] d;
    int dc;
    b1 = frame(seg(8'h02, 8'h01, 1'b0, 1'b0), seg(8'h02, 8'h01, 1'b0, 1'b1),
               seg(8'h05, 8'h05, 1'b1, 1'b0), 9'h155, 9'h0AA);
    dc = m.done_cnt;
    m.load(b1, 144, 1'b0, 0);
    wait_idle();
    chk("done_rises", 32'(dc + 1), 32'(m.done_cnt));
    chk("done", 32'h0, 32'(done));
    chk("pump", 32'h155, 32'(pump));
    chk("filter", 32'h0AA, 32'(filt));
    reg_rd(BW_OFF, d);
    chk("bw", 32'h00AA_0155, d);
    reg_rd(STATE_OFF, d);
    chk("shift_cnt", 32'(SCNT_FULL), 32'(d[15:8]));
    reg_rd(STATUS_OFF, d);
    chk("status", 32'h1, d);
    chk("irq", 32'h1, 32'(irq));
    reg_wr(STATUS_OFF, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    meas(0, 4, 6);
    meas(1, 3, 6);
    meas(2, 1, 2);
    d = {28'h0, fb, pre, odiv[4:3]};
    @(negedge clk);
    chk("bypass", d ^ 32'hF, {28'h0, fb, pre, odiv[4:3]});
  endtask
  // Slower scan clock; the old chain must come out bit by bit.
  task t_reload();
    int dc;
    b2 = frame(seg(8'h03, 8'h03, 1'b0, 1'b0), seg(8'h01, 8'h01, 1'b1, 1'b0),
               seg(8'h02, 8'h01, 1'b0, 1'b1), 9'h0F0, 9'h10F);
    dc = m.done_cnt;
    m.load(b2, 144, 1'b0, 3);
    chk_v("readback", b1, m.rb);
    wait_idle();
    chk("done_rises", 32'(dc + 1), 32'(m.done_cnt));
    chk("pump", 32'h0F0, 32'(pump));
    chk("filter", 32'h10F, 32'(filt));
    meas(0, 6, 12);
    meas(2, 3, 6);
    reg_wr(STATUS_OFF, 32'h1);
  endtask
  // A short load and an apply with the enable still high are ignored.
  task t_refuse();
    logic [31:0] d;
    int dc;
    dc = m.done_cnt;
    m.load(b1, 100, 1'b0, 0);
    m.load(b1, 144, 1'b1, 0);
    repeat (4) @(negedge clk);
    chk("done_rises", 32'(dc), 32'(m.done_cnt));
    chk("pump", 32'h0F0, 32'(pump));
    reg_rd(STATUS_OFF, d);
    chk("status", 32'h2, d);
    chk("irq_masked", 32'h0, 32'(irq));
    reg_wr(MASK_OFF, 32'h3);
    chk("irq", 32'h1, 32'(irq));
    reg_wr(STATUS_OFF, 32'h2);
    chk("irq", 32'h0, 32'(irq));
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    we = 1'b0;
    re = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_load1();
    t_reload();
    t_refuse();
    finish_test();
  end
endmodule
